// *** tupfs_defs.vh ***
`ifndef TUPFS_DEFS_VH
`define TUPFS_DEFS_VH
// register byte addresses
`define TUPFS_ADDR_UNIT1     8'h08
`define TUPFS_ADDR_UNIT2     8'h0c
`define TUPFS_RESET_VALUE    32'h0000_0000
// field positions (low bit)
`define TUPFS_CAP3_LSB       29
`define TUPFS_CAP2_LSB       26
`define TUPFS_CAP1_LSB       23
`define TUPFS_CAP0_LSB       20
`define TUPFS_CLK_LSB        18
`define TUPFS_EMG_LSB        16
`define TUPFS_GPIO_BIT       12
`define TUPFS_U1_RW_MASK     32'h000f_1fff
`define TUPFS_U2_RW_MASK     32'hffff_1fff
// route codes
`define TUPFS_RT_OFF         2'h0
`define TUPFS_RT_PIN0        2'h1
`define TUPFS_RT_PIN1        2'h2
`define TUPFS_SEL_PIN0A      2'h0
`define TUPFS_SEL_PIN0B      2'h1
`define TUPFS_SEL_PIN1       2'h2
`define TUPFS_CAP_PIN0A      3'h0
`define TUPFS_CAP_PIN0B      3'h1
`define TUPFS_CAP_PIN1       3'h2
`define TUPFS_CAP_SYNC_LO    3'h4
`define TUPFS_CAP_SYNC_HI    3'h5
`endif

// *** tupfs_unit.v ***
`timescale 1ns/1ps
`default_nettype none
`include "tupfs_defs.vh"
// routing of one timer unit, purely combinational from its register image
module tupfs_unit
#(
   parameter HAS_CAPTURE = 1
)
(
   // register image
   input  wire [31:0] cfg_in,
   // emergency flag from waveform generator
   input  wire        emergency_flag_in,
   // pin-side inputs, two variants each, then the serial channel sync detects
   input  wire [1:0]  clock_pin_in,
   input  wire [1:0]  emergency_pin_in,
   input  wire [7:0]  capture_pin_in,
   input  wire [7:0]  serial_sync_in,
   // timer-side inputs
   output wire        freerun_clock_out,
   output wire        emergency_input_out,
   output wire [3:0]  capture_out,
   // waveform outputs
   input  wire [5:0]  wave_in,
   output wire [5:0]  wave_pin0_out,
   output wire [5:0]  wave_pin1_out,
   output wire [5:0]  wave_pin0_oe_n_out,
   output wire [5:0]  wave_pin1_oe_n_out,
   output wire [5:0]  wave_gpio_out
);

   // two-bit input selector; forbidden code leaves the route idle
   function sel2;
      input [1:0] code;
      input [1:0] pins;
      begin
         case (code)
            `TUPFS_SEL_PIN0A: sel2 = pins[0];
            `TUPFS_SEL_PIN0B: sel2 = pins[0];
            `TUPFS_SEL_PIN1:  sel2 = pins[1];
            default:          sel2 = 1'b0;
         endcase
      end
   endfunction

   function sel3;
      input [2:0] code;
      input [1:0] pins;
      input [1:0] syncs;
      begin
         case (code)
            `TUPFS_CAP_PIN0A:   sel3 = pins[0];
            `TUPFS_CAP_PIN0B:   sel3 = pins[0];
            `TUPFS_CAP_PIN1:    sel3 = pins[1];
            `TUPFS_CAP_SYNC_LO: sel3 = syncs[0];
            `TUPFS_CAP_SYNC_HI: sel3 = syncs[1];
            default:            sel3 = 1'b0;
         endcase
      end
   endfunction

   wire gpio_take = cfg_in[`TUPFS_GPIO_BIT] & emergency_flag_in;

   assign freerun_clock_out   = sel2(cfg_in[`TUPFS_CLK_LSB +: 2], clock_pin_in);
   assign emergency_input_out = sel2(cfg_in[`TUPFS_EMG_LSB +: 2], emergency_pin_in);

   genvar i;
   generate
      for (i = 0; i < 4; i = i + 1)
      begin : g_cap
         // serial sync pairs: channel i and channel i+4
         if (HAS_CAPTURE != 0)
         begin : g_on
            assign capture_out[i] = sel3(cfg_in[`TUPFS_CAP0_LSB + 3 * i +: 3], capture_pin_in[2 * i +: 2],
                                         {serial_sync_in[i + 4], serial_sync_in[i]});
         end
         else
         begin : g_off
            assign capture_out[i] = 1'b0;
         end
      end
      for (i = 0; i < 6; i = i + 1)
      begin : g_wave
         wire [1:0] rt = cfg_in[2 * i +: 2];
         wire       en0 = (rt == `TUPFS_RT_PIN0) & ~gpio_take;
         wire       en1 = (rt == `TUPFS_RT_PIN1) & ~gpio_take;
         assign wave_pin0_out[i]      = wave_in[i] & en0;
         assign wave_pin1_out[i]      = wave_in[i] & en1;
         assign wave_pin0_oe_n_out[i] = ~en0;
         assign wave_pin1_oe_n_out[i] = ~en1;
         // pin handed back to port logic while stopped
         assign wave_gpio_out[i]      = gpio_take & ((rt == `TUPFS_RT_PIN0) | (rt == `TUPFS_RT_PIN1));
      end
   endgenerate

endmodule // tupfs_unit
`default_nettype wire

// *** tupfs_top.v ***
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "tupfs_defs.vh"
// Behaviour
// - unit-1 clock selector: 00/01 pin variant 0, 10 variant 1, reset 00.
// - unit-1 emergency selector: 00/01 variant 0, 10 variant 1, reset 00.
// - unit-1 bits 15:13 always read zero.
// - unit-1 switch bit set lets emergency flag hand wave pins to GPIO.
// - unit-1 wave 5 route: 00 off, 01 variant 0, 10 variant 1.
// - unit-1 wave 4 route: 00 off, 01 variant 0, 10 variant 1.
// - unit-1 wave 3 route: 00 off, 01 variant 0, 10 variant 1.
// - unit-1 wave 2 route: 00 off, 01 variant 0, 10 variant 1.
// - unit-1 wave 1 route: 00 off, 01 variant 0, 10 variant 1.
// - unit-1 wave 0 route: 00 off, 01 variant 0, 10 variant 1.
// - registers survive deep-standby reset; other resets clear them.
// - unit-1 register is a build option, absent on variant three.
// - unit-2 register is a build option, absent on variants 0, 1, 3.
// - unit-2 layout: four capture selectors, clock, emergency, switch, six routes.
// - unit-2 capture 3: pins, or serial channel 3 / 7 sync.
// - unit-2 capture 2: pins, or serial channel 2 / 6 sync.
// - unit-2 capture 1: pins, or serial channel 1 / 5 sync.
// - unit-2 capture 0: pins, or serial channel 0 / 4 sync.
// - unit-2 switch bit lets unit-2 emergency flag hand pins to GPIO.
// - unit-2 wave routes: 00 off, 01 variant 0, 10 variant 1.
module tupfs_top
#(
   parameter HAS_UNIT1 = 1,
   parameter HAS_UNIT2 = 1
)
(
   // clock, resets, enable
   input  wire        clk_in,
   input  wire        rst_in,
   input  wire        deep_standby_reset_in,
   input  wire        clk_en_in,
   // register port
   input  wire [7:0]  addr_in,
   input  wire [31:0] wdata_in,
   input  wire        wr_in,
   input  wire        rd_in,
   output reg  [31:0] rdata_out,
   // unit 1 pins and timer side
   input  wire        u1_emergency_flag_in,
   input  wire [1:0]  u1_freerun_clock_pin_in,
   input  wire [1:0]  u1_emergency_input_pin_in,
   output wire        u1_freerun_clock_out,
   output wire        u1_emergency_input_out,
   input  wire [5:0]  u1_wave_in,
   output wire [5:0]  u1_wave_pin0_out,
   output wire [5:0]  u1_wave_pin1_out,
   output wire [5:0]  u1_wave_pin0_oe_n_out,
   output wire [5:0]  u1_wave_pin1_oe_n_out,
   output wire [5:0]  u1_wave_gpio_out,
   // unit 2 pins and timer side
   input  wire        u2_emergency_flag_in,
   input  wire [1:0]  u2_freerun_clock_pin_in,
   input  wire [1:0]  u2_emergency_input_pin_in,
   input  wire [7:0]  u2_capture_pin_in,
   input  wire [7:0]  serial_sync_detect_in,
   output wire        u2_freerun_clock_out,
   output wire        u2_emergency_input_out,
   output wire [3:0]  u2_capture_out,
   input  wire [5:0]  u2_wave_in,
   output wire [5:0]  u2_wave_pin0_out,
   output wire [5:0]  u2_wave_pin1_out,
   output wire [5:0]  u2_wave_pin0_oe_n_out,
   output wire [5:0]  u2_wave_pin1_oe_n_out,
   output wire [5:0]  u2_wave_gpio_out
);

   reg  [31:0] unit1_ff;
   reg  [31:0] unit2_ff;
   reg  [31:0] nxt_rdata;
   wire        hit1 = (addr_in == `TUPFS_ADDR_UNIT1) && (HAS_UNIT1 != 0);
   wire        hit2 = (addr_in == `TUPFS_ADDR_UNIT2) && (HAS_UNIT2 != 0);
   wire [31:0] img1 = (HAS_UNIT1 != 0) ? unit1_ff : `TUPFS_RESET_VALUE;
   wire [31:0] img2 = (HAS_UNIT2 != 0) ? unit2_ff : `TUPFS_RESET_VALUE;

   // deep-standby reset is not wired into these flops on purpose
   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         unit1_ff  <= `TUPFS_RESET_VALUE;
         unit2_ff  <= `TUPFS_RESET_VALUE;
         rdata_out <= 32'h0000_0000;
      end
      else if (clk_en_in)
      begin
         // reserved bits 15:13 and unit-1 capture bits never stored
         if (wr_in && hit1)
         begin
            unit1_ff <= wdata_in & `TUPFS_U1_RW_MASK;
         end
         if (wr_in && hit2)
         begin
            unit2_ff <= wdata_in & `TUPFS_U2_RW_MASK;
         end
         rdata_out <= nxt_rdata;
      end
   end

   // read data valid only in the cycle after an enabled strobe, zero after other enabled cycles, held while disabled
   always @*
   begin
      nxt_rdata = 32'h0000_0000;
      if (rd_in && hit1)
      begin
         nxt_rdata = unit1_ff;
      end
      else if (rd_in && hit2)
      begin
         nxt_rdata = unit2_ff;
      end
   end

   // unit 1: capture selectors live elsewhere
   tupfs_unit #(.HAS_CAPTURE(0)) u_unit1
   (
      .cfg_in              (img1),
      .emergency_flag_in   (u1_emergency_flag_in),
      .clock_pin_in        (u1_freerun_clock_pin_in),
      .emergency_pin_in    (u1_emergency_input_pin_in),
      .capture_pin_in      (8'h00),
      .serial_sync_in      (8'h00),
      .freerun_clock_out   (u1_freerun_clock_out),
      .emergency_input_out (u1_emergency_input_out),
      .capture_out         (),
      .wave_in             (u1_wave_in),
      .wave_pin0_out       (u1_wave_pin0_out),
      .wave_pin1_out       (u1_wave_pin1_out),
      .wave_pin0_oe_n_out  (u1_wave_pin0_oe_n_out),
      .wave_pin1_oe_n_out  (u1_wave_pin1_oe_n_out),
      .wave_gpio_out       (u1_wave_gpio_out)
   );

   tupfs_unit #(.HAS_CAPTURE(1)) u_unit2
   (
      .cfg_in              (img2),
      .emergency_flag_in   (u2_emergency_flag_in),
      .clock_pin_in        (u2_freerun_clock_pin_in),
      .emergency_pin_in    (u2_emergency_input_pin_in),
      .capture_pin_in      (u2_capture_pin_in),
      .serial_sync_in      (serial_sync_detect_in),
      .freerun_clock_out   (u2_freerun_clock_out),
      .emergency_input_out (u2_emergency_input_out),
      .capture_out         (u2_capture_out),
      .wave_in             (u2_wave_in),
      .wave_pin0_out       (u2_wave_pin0_out),
      .wave_pin1_out       (u2_wave_pin1_out),
      .wave_pin0_oe_n_out  (u2_wave_pin0_oe_n_out),
      .wave_pin1_oe_n_out  (u2_wave_pin1_oe_n_out),
      .wave_gpio_out       (u2_wave_gpio_out)
   );

   // deep standby reset deliberately has no effect here
   wire unused_ok = deep_standby_reset_in;

endmodule // tupfs_top
`default_nettype wire

// *** tupfs_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tupfs_defs.vh"
module tupfs_properties
(
   // watched top ports
   input wire logic        clk_in,
   input wire logic        rst_in,
   input wire logic        clk_en_in,
   input wire logic [7:0]  addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic        wr_in,
   input wire logic        rd_in,
   input wire logic [31:0] rdata_out,
   input wire logic        u1_emergency_flag_in,
   input wire logic [1:0]  u1_freerun_clock_pin_in,
   input wire logic        u1_freerun_clock_out,
   input wire logic [5:0]  u1_wave_pin0_oe_n_out,
   input wire logic [5:0]  u1_wave_gpio_out,
   input wire logic [7:0]  u2_capture_pin_in,
   input wire logic [7:0]  serial_sync_detect_in,
   input wire logic [3:0]  u2_capture_out,
   input wire logic [5:0]  u2_wave_pin1_oe_n_out,
   input wire logic [5:0]  u2_wave_gpio_out
);
   // shadow images, so routing is judged against what software wrote
   logic [31:0] sh1_ff;
   logic [31:0] sh2_ff;
   logic [3:0]  cap_exp;
   function automatic logic [5:0] rte(input logic [31:0] c, input logic [1:0] k);
      for (int i = 0; i < 6; i++)
         rte[i] = c[2*i +: 2] == k;
   endfunction
   always_ff @(posedge clk_in or posedge rst_in)
      if (rst_in)
      begin
         sh1_ff <= '0;
         sh2_ff <= '0;
      end
      else if (clk_en_in && wr_in)
      begin
         if (addr_in == `TUPFS_ADDR_UNIT1)
            sh1_ff <= wdata_in & `TUPFS_U1_RW_MASK;
         if (addr_in == `TUPFS_ADDR_UNIT2)
            sh2_ff <= wdata_in & `TUPFS_U2_RW_MASK;
      end
   always_comb
      for (int j = 0; j < 4; j++)
         case (sh2_ff[20+3*j +: 3])
            3'h0, 3'h1: cap_exp[j] = u2_capture_pin_in[2*j];
            3'h2: cap_exp[j] = u2_capture_pin_in[2*j+1];
            3'h4: cap_exp[j] = serial_sync_detect_in[j];
            3'h5: cap_exp[j] = serial_sync_detect_in[j+4];
            default: cap_exp[j] = 1'b0;
         endcase
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   sequence rd_u1_s;
      clk_en_in && rd_in && addr_in == `TUPFS_ADDR_UNIT1;
   endsequence
   sequence rd_u2_s;
      clk_en_in && rd_in && addr_in == `TUPFS_ADDR_UNIT2;
   endsequence
   AST_RD_U1: assert property (rd_u1_s |=> rdata_out == sh1_ff)
      else $error("unit-1 read data wrong");
   AST_RD_U2: assert property (rd_u2_s |=> rdata_out == sh2_ff)
      else $error("unit-2 read data wrong");
   AST_RD_IDLE: assert property (clk_en_in && !rd_in |=> rdata_out == 32'h0)
      else $error("read data not zero outside read");
   AST_U1_CLK: assert property (u1_freerun_clock_out == (sh1_ff[19:18] == 2'h2 ? u1_freerun_clock_pin_in[1]
      : sh1_ff[19:18] != 2'h3 && u1_freerun_clock_pin_in[0])) else $error("unit-1 clock source wrong");
   AST_U1_GPIO: assert property (u1_wave_gpio_out == ((rte(sh1_ff, 2'h1) | rte(sh1_ff, 2'h2))
      & {6{sh1_ff[12] & u1_emergency_flag_in}})) else $error("unit-1 gpio handover wrong");
   AST_U1_OE: assert property (u1_wave_pin0_oe_n_out == ~(rte(sh1_ff, 2'h1) & ~u1_wave_gpio_out))
      else $error("unit-1 pin0 enables wrong");
   AST_U2_CAP: assert property (u2_capture_out == cap_exp)
      else $error("unit-2 capture source wrong");
   AST_U2_OE: assert property (u2_wave_pin1_oe_n_out == ~(rte(sh2_ff, 2'h2) & ~u2_wave_gpio_out))
      else $error("unit-2 pin1 enables wrong");
endmodule // tupfs_properties
bind tupfs_top tupfs_properties u_props (.clk_in, .rst_in, .clk_en_in, .addr_in, .wdata_in, .wr_in, .rd_in,
   .rdata_out, .u1_emergency_flag_in, .u1_freerun_clock_pin_in, .u1_freerun_clock_out, .u1_wave_pin0_oe_n_out,
   .u1_wave_gpio_out, .u2_capture_pin_in, .serial_sync_detect_in, .u2_capture_out, .u2_wave_pin1_oe_n_out,
   .u2_wave_gpio_out);
`default_nettype wire

// *** tupfs_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tupfs_defs.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("mismatch %0t: %h vs %h", $time, (g), (e)); end end
module tupfs_tb;
   logic        clk_in = 0, rst_in = 1, dsr = 0, wr = 0, rd = 0, rd_seen = 0, f1 = 0, f2 = 0, ce = 1;
   logic [7:0]  addr = 0, cpin = 0, sync = 0;
   logic [31:0] wdata = 0, v, r, q[$];
   logic [1:0]  p1c = 0, p1e = 0, p2c = 0, p2e = 0, kc;
   logic [5:0]  w1 = 0, w2 = 0;
   wire  [31:0] rdata;
   wire         c1, e1, c2, e2;
   wire  [3:0]  cap;
   wire  [5:0]  a1, b1, an1, bn1, g1, a2, b2, an2, bn2, g2;
   int          mismatches = 0, total_checks = 0;
   tupfs_top dut (.clk_in(clk_in), .rst_in(rst_in), .deep_standby_reset_in(dsr), .clk_en_in(ce), .addr_in(addr),
      .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .u1_emergency_flag_in(f1),
      .u1_freerun_clock_pin_in(p1c), .u1_emergency_input_pin_in(p1e), .u1_freerun_clock_out(c1),
      .u1_emergency_input_out(e1), .u1_wave_in(w1), .u1_wave_pin0_out(a1), .u1_wave_pin1_out(b1),
      .u1_wave_pin0_oe_n_out(an1), .u1_wave_pin1_oe_n_out(bn1), .u1_wave_gpio_out(g1), .u2_emergency_flag_in(f2),
      .u2_freerun_clock_pin_in(p2c), .u2_emergency_input_pin_in(p2e), .u2_capture_pin_in(cpin),
      .serial_sync_detect_in(sync), .u2_freerun_clock_out(c2), .u2_emergency_input_out(e2), .u2_capture_out(cap),
      .u2_wave_in(w2), .u2_wave_pin0_out(a2), .u2_wave_pin1_out(b2), .u2_wave_pin0_oe_n_out(an2),
      .u2_wave_pin1_oe_n_out(bn2), .u2_wave_gpio_out(g2));
   always #50 clk_in = ~clk_in;
   function automatic logic sx(input logic [1:0] c, input logic [1:0] p);
      return c == 2'h2 ? p[1] : (c != 2'h3 && p[0]);
   endfunction
   // capture selector: pins, low or high sync channel, forbidden codes idle
   function automatic logic cx(input logic [2:0] c, input logic [1:0] p, input logic [1:0] s);
      return c < 3'h2 ? p[0] : c == 3'h2 ? p[1] : c == 3'h4 ? s[0] : (c == 3'h5 && s[1]);
   endfunction
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      if (!w)
         q.push_back(d);
      @(posedge clk_in);
      wr <= 0;
      rd <= 0;
   endtask
   task automatic unit(input [5:0] g, an, bn, a, b, w, input logic f, input int k);
      logic [5:0] e0, e1x, gp;
      e0 = k[1:0] == 2'h1 ? 6'h3f : 6'h0;
      e1x = k[1:0] == 2'h2 ? 6'h3f : 6'h0;
      gp = (e0 | e1x) & {6{k[3] & f}};
      `CHK(g, gp)
      `CHK(an, ~(e0 & ~gp))
      `CHK(bn, ~(e1x & ~gp))
      `CHK(a & ~an | b & ~bn, w & (e0 | e1x) & ~gp)
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge clk_in)
      rd_seen <= rd;
   always @(negedge clk_in)
      if (rd_seen)
         `CHK(rdata, q.pop_front())
   initial
   begin
      #300000;
      mismatches++;
      end_sim;
   end
   initial
   begin
      v = $urandom(96743);
      repeat (4) @(posedge clk_in);
      rst_in <= 0;
      acc(0, `TUPFS_ADDR_UNIT1, 0);
      acc(0, `TUPFS_ADDR_UNIT2, 0);
      acc(0, 8'h10, 0);
      $display("reset values done");
      repeat (6)
      begin
         v = $urandom;
         // software keeps bits 15:13 at zero
         acc(1, `TUPFS_ADDR_UNIT1, v & `TUPFS_U2_RW_MASK);
         acc(1, 8'h10, 0);
         acc(0, `TUPFS_ADDR_UNIT1, v & `TUPFS_U1_RW_MASK);
         acc(1, `TUPFS_ADDR_UNIT2, ~v);
         acc(0, `TUPFS_ADDR_UNIT2, ~v & `TUPFS_U2_RW_MASK);
      end
      $display("register access done");
      for (int k = 0; k < 16; k++)
      begin
         v = {{4{k[2:0]}}, {2{k[1:0]}}, 3'h0, k[3], {6{k[1:0]}}};
         acc(1, `TUPFS_ADDR_UNIT1, v);
         acc(1, `TUPFS_ADDR_UNIT2, v);
         r = $urandom;
         {cpin, sync, p1c, p1e, p2c, p2e} <= r[23:0];
         r = $urandom;
         {f1, f2, w1, w2} <= r[13:0];
         kc = k[1:0];
         @(negedge clk_in);
         unit(g1, an1, bn1, a1, b1, w1, f1, k);
         unit(g2, an2, bn2, a2, b2, w2, f2, k);
         `CHK({c1, e1, c2, e2}, {sx(kc, p1c), sx(kc, p1e), sx(kc, p2c), sx(kc, p2e)})
         for (int j = 0; j < 4; j++)
            `CHK(cap[j], cx(k[2:0], cpin[2*j +: 2], {sync[j+4], sync[j]}))
      end
      $display("routing done");
      @(posedge clk_in);
      dsr <= 1;
      @(posedge clk_in);
      dsr <= 0;
      acc(0, `TUPFS_ADDR_UNIT1, v & `TUPFS_U1_RW_MASK);
      @(posedge clk_in);
      rst_in <= 1;
      @(posedge clk_in);
      rst_in <= 0;
      acc(0, `TUPFS_ADDR_UNIT2, 0);
      // a write while the enable is low must not land
      ce <= 0;
      acc(1, `TUPFS_ADDR_UNIT2, 32'h0000_1155);
      ce <= 1;
      acc(0, `TUPFS_ADDR_UNIT2, 0);
      repeat (2) @(posedge clk_in);
      $display("standby reset done");
      end_sim;
   end
endmodule // tupfs_tb
`default_nettype wire
